// ===== logic/ctrl_reg_map.svh
// register offsets, field masks, bit positions and reset values of the control register bank
`ifndef CTRL_REG_MAP_SVH
`define CTRL_REG_MAP_SVH

`define ADDR_IFACE_BASE 16'h0800
`define ADDR_IFACE_LAST 16'h0807
`define ADDR_PIN_LEVEL 16'h0808
`define ADDR_AUX_BASE 16'h0809
`define ADDR_AUX_LAST 16'h080c
`define ADDR_CAPTURE_0 16'h081a
`define ADDR_CAPTURE_1 16'h081b
`define ADDR_CORE_CONTROL 16'h081c
`define ADDR_RESERVED_081D 16'h081d
`define ADDR_SERIAL_OUT 16'h081e
`define ADDR_SERIAL_IN 16'h081f
`define ADDR_PIN_FUNC_0 16'h0820
`define ADDR_PIN_FUNC_1 16'h0821
`define ADDR_AUX_POWER 16'h0822
`define ADDR_RESERVED_0823 16'h0823
`define ADDR_AUX_ENABLE 16'h0824
`define ADDR_RESERVED_0825 16'h0825
`define ADDR_OSC_SHUTDOWN 16'h0826
`define ADDR_OUT_CONV_SETUP 16'h0827

`define MASK_IFACE 32'h0fff_ffff
`define MASK_PIN_LEVEL 32'h0000_0fff
`define MASK_AUX_DATA 32'h0000_0fff
`define MASK_CAPTURE 32'h0000_0fff
`define MASK_CORE_CONTROL 32'h0000_31ff
`define MASK_SERIAL_OUT 32'h0000_3fff
`define MASK_SERIAL_IN 32'h0000_001f
`define MASK_PIN_FUNC 32'h00ff_ffff
`define MASK_AUX_POWER 32'h0000_03ef
`define MASK_AUX_ENABLE 32'h0000_8000
`define MASK_OSC_SHUTDOWN 32'h0000_0004
`define MASK_OUT_CONV_SETUP 32'h0000_0003

`define BIT_AUX_PORT_WRITE 8
`define BIT_PIN_PORT_WRITE 7
`define BIT_IFACE_PORT_WRITE 6

`define RESET_WORD 32'h0000_0000

`endif

// ===== logic/ctrl_reg_pkg.sv
// types shared by the control register bank and its frame event synchroniser
package ctrl_reg_pkg;

  typedef logic [7:0][27:0] iface_words_t;
  typedef logic [3:0][11:0] aux_words_t;
  typedef logic [31:0] reg_word_t;

endpackage : ctrl_reg_pkg

// ===== logic/frame_event_if.sv
// frame and save-trigger events passed from the synchroniser to the register bank
`timescale 1ns/10ps
interface frame_event_if;
  logic save_edge_rising;
  logic frame_tick;
  logic save_tick;

  modport sync (
    input save_edge_rising,
    output frame_tick,
    output save_tick
  );

  modport bank (
    output save_edge_rising,
    input frame_tick,
    input save_tick
  );
endinterface : frame_event_if

// ===== logic/frame_event_sync.sv
// synchronises the frame clock and save trigger pins and turns the frame clock's rising edge and the selected save trigger edge into one-cycle ticks
`timescale 1ns/10ps
module frame_event_sync
  import ctrl_reg_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic frame_clk_i,
  input wire logic save_trig_i,
  frame_event_if.sync ev
);

  logic [1:0] pin_in;
  logic [1:0] stage1_q;
  logic [1:0] stage2_q;
  logic [1:0] stage3_q;
  logic [1:0] level_q;
  logic [1:0] level_d;
  logic frame_tick_q;
  logic frame_tick_d;
  logic save_tick_q;
  logic save_tick_d;

  assign pin_in = {save_trig_i, frame_clk_i};

  // a change counts only once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      always_comb begin
        level_d[g] = (stage2_q[g] == stage3_q[g]) ? stage3_q[g] : level_q[g];
      end
    end
  endgenerate

  always_comb begin
    frame_tick_d = level_d[0] & ~level_q[0];
    save_tick_d = ev.save_edge_rising ? (level_d[1] & ~level_q[1]) : (~level_d[1] & level_q[1]); // [RULE4]
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1_q <= 2'h0;
      stage2_q <= 2'h0;
      stage3_q <= 2'h0;
      level_q <= 2'h0;
      frame_tick_q <= 1'b0;
      save_tick_q <= 1'b0;
    end else begin
      stage1_q <= pin_in;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q <= level_d;
      frame_tick_q <= frame_tick_d;
      save_tick_q <= save_tick_d;
    end
  end

  assign ev.frame_tick = frame_tick_q;
  assign ev.save_tick = save_tick_q;

endmodule : frame_event_sync

// ===== logic/control_register_bank.sv
// control-port register bank of the audio processor, refreshed once per sample frame
// Function
// [RULE1] eight 32-bit interface registers, 28-bit parameters
// [RULE2] parameter in bits 27:0, top four zero
// [RULE3] refresh from parameter memory each frame
// [RULE4] selectable save edge writes registers to EEPROM
// [RULE5] port-write mode lets host fill interface registers
// [RULE6] saved parameters restored after reset or power-up
// [RULE7] host sets pin levels only in pin-write mode
// [RULE8] pin setting register updated once per frame
// [RULE9] twelve pin level bits, bits 15:12 zero
// [RULE10] capture selector: 10-bit step, 2-bit source
// [RULE11] aux-data port-write mode lets host write aux data
// [RULE12] reserved and zero bits read zero, ignore writes
`timescale 1ns/10ps
`include "ctrl_reg_map.svh"
module control_register_bank
  import ctrl_reg_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  input wire logic frame_clk_i,
  input wire logic save_trig_i,
  input wire logic save_edge_rising_i,
  input wire iface_words_t param_word_i,
  input wire logic restore_valid_i,
  input wire iface_words_t restore_data_i,
  output logic save_strobe_o,
  output iface_words_t save_data_o,
  input wire logic [11:0] gpio_level_i,
  output logic [11:0] gpio_level_o,
  input wire aux_words_t aux_adc_data_i,
  output aux_words_t aux_data_o,
  output logic [15:0] core_control_o,
  output logic [11:0] capture_select_0_o,
  output logic [11:0] capture_select_1_o,
  output logic [15:0] serial_output_config_o,
  output logic [7:0] serial_input_config_o,
  output logic [23:0] pin_function_config_0_o,
  output logic [23:0] pin_function_config_1_o,
  output logic [15:0] aux_converter_power_control_o,
  output logic [15:0] aux_converter_enable_o,
  output logic [15:0] oscillator_shutdown_o,
  output logic [15:0] output_converter_setup_o
);

  frame_event_if ev ();

  frame_event_sync u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .frame_clk_i(frame_clk_i),
    .save_trig_i(save_trig_i),
    .ev(ev.sync)
  );

  assign ev.save_edge_rising = save_edge_rising_i;

  // writable bits of each mapped word; an unmapped address has none
  function automatic logic [31:0] write_mask(input logic [15:0] a);
    logic [31:0] m;
    m = `RESET_WORD;
    if (a >= `ADDR_IFACE_BASE && a <= `ADDR_IFACE_LAST) begin
      m = `MASK_IFACE;
    end else if (a >= `ADDR_AUX_BASE && a <= `ADDR_AUX_LAST) begin
      m = `MASK_AUX_DATA;
    end else begin
      unique case (a)
        `ADDR_PIN_LEVEL: m = `MASK_PIN_LEVEL;
        `ADDR_CAPTURE_0: m = `MASK_CAPTURE;
        `ADDR_CAPTURE_1: m = `MASK_CAPTURE;
        `ADDR_CORE_CONTROL: m = `MASK_CORE_CONTROL;
        `ADDR_SERIAL_OUT: m = `MASK_SERIAL_OUT;
        `ADDR_SERIAL_IN: m = `MASK_SERIAL_IN;
        `ADDR_PIN_FUNC_0: m = `MASK_PIN_FUNC;
        `ADDR_PIN_FUNC_1: m = `MASK_PIN_FUNC;
        `ADDR_AUX_POWER: m = `MASK_AUX_POWER;
        `ADDR_AUX_ENABLE: m = `MASK_AUX_ENABLE;
        `ADDR_OSC_SHUTDOWN: m = `MASK_OSC_SHUTDOWN;
        `ADDR_OUT_CONV_SETUP: m = `MASK_OUT_CONV_SETUP;
        default: m = `RESET_WORD;
      endcase
    end
    return m;
  endfunction : write_mask

  function automatic logic is_iface(input logic [15:0] a);
    return (a >= `ADDR_IFACE_BASE) && (a <= `ADDR_IFACE_LAST);
  endfunction : is_iface

  function automatic logic is_aux(input logic [15:0] a);
    return (a >= `ADDR_AUX_BASE) && (a <= `ADDR_AUX_LAST);
  endfunction : is_aux

  iface_words_t iface_q;
  iface_words_t iface_d;
  iface_words_t save_data_q;
  iface_words_t save_data_d;
  logic save_strobe_q;
  logic save_strobe_d;
  logic [11:0] pin_level_q;
  logic [11:0] pin_level_d;
  logic [11:0] gpio_out_q;
  logic [11:0] gpio_out_d;
  aux_words_t aux_q;
  aux_words_t aux_d;
  logic [11:0] capture_0_q;
  logic [11:0] capture_0_d;
  logic [11:0] capture_1_q;
  logic [11:0] capture_1_d;
  logic [15:0] core_q;
  logic [15:0] core_d;
  logic [15:0] serial_out_q;
  logic [15:0] serial_out_d;
  logic [7:0] serial_in_q;
  logic [7:0] serial_in_d;
  logic [23:0] pin_func_0_q;
  logic [23:0] pin_func_0_d;
  logic [23:0] pin_func_1_q;
  logic [23:0] pin_func_1_d;
  logic [15:0] aux_power_q;
  logic [15:0] aux_power_d;
  logic [15:0] aux_enable_q;
  logic [15:0] aux_enable_d;
  logic [15:0] osc_q;
  logic [15:0] osc_d;
  logic [15:0] conv_setup_q;
  logic [15:0] conv_setup_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  logic [31:0] wmasked;
  logic iface_mode;
  logic pin_mode;
  logic aux_mode;
  logic [2:0] iface_idx;
  logic [1:0] aux_idx;
  logic [15:0] aux_off;

  always_comb begin
    wmasked = wdata_i & write_mask(addr_i); // [RULE12]
    iface_mode = core_q[`BIT_IFACE_PORT_WRITE];
    pin_mode = core_q[`BIT_PIN_PORT_WRITE];
    aux_mode = core_q[`BIT_AUX_PORT_WRITE];
    iface_idx = addr_i[2:0];
    aux_off = addr_i - `ADDR_AUX_BASE;
    aux_idx = aux_off[1:0];
  end

  // interface words: restore wins, then host writes in port-write mode, else frame refresh
  always_comb begin
    iface_d = iface_q;
    save_data_d = save_data_q;
    save_strobe_d = 1'b0;
    if (restore_valid_i) begin
      iface_d = restore_data_i; // [RULE6]
    end else if (iface_mode) begin
      if (wr_en_i && is_iface(addr_i)) begin
        iface_d[iface_idx] = wmasked[27:0]; // [RULE5] [RULE1] [RULE2]
      end
    end else if (ev.frame_tick) begin
      iface_d = param_word_i; // [RULE3]
    end
    if (ev.save_tick) begin
      save_data_d = iface_q; // [RULE4]
      save_strobe_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      iface_q <= '0;
      save_data_q <= '0;
      save_strobe_q <= 1'b0;
    end else begin
      iface_q <= iface_d;
      save_data_q <= save_data_d;
      save_strobe_q <= save_strobe_d;
    end
  end

  // pin levels and auxiliary data follow the frame unless the host owns them
  always_comb begin
    pin_level_d = pin_level_q;
    gpio_out_d = gpio_out_q;
    aux_d = aux_q;
    if (pin_mode) begin
      if (wr_en_i && addr_i == `ADDR_PIN_LEVEL) begin
        pin_level_d = wmasked[11:0]; // [RULE7] [RULE9]
      end
    end else if (ev.frame_tick) begin
      pin_level_d = gpio_level_i; // [RULE8]
    end
    if (ev.frame_tick) begin
      gpio_out_d = pin_level_q; // [RULE8]
    end
    if (aux_mode) begin
      if (wr_en_i && is_aux(addr_i)) begin
        aux_d[aux_idx] = wmasked[11:0]; // [RULE11]
      end
    end else if (ev.frame_tick) begin
      aux_d = aux_adc_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_level_q <= 12'h000;
      gpio_out_q <= 12'h000;
      aux_q <= '0;
    end else begin
      pin_level_q <= pin_level_d;
      gpio_out_q <= gpio_out_d;
      aux_q <= aux_d;
    end
  end

  // plain configuration words; only masked bits are stored
  always_comb begin
    capture_0_d = capture_0_q;
    capture_1_d = capture_1_q;
    core_d = core_q;
    serial_out_d = serial_out_q;
    serial_in_d = serial_in_q;
    pin_func_0_d = pin_func_0_q;
    pin_func_1_d = pin_func_1_q;
    aux_power_d = aux_power_q;
    aux_enable_d = aux_enable_q;
    osc_d = osc_q;
    conv_setup_d = conv_setup_q;
    if (wr_en_i) begin
      unique case (addr_i)
        `ADDR_CAPTURE_0: capture_0_d = wmasked[11:0]; // [RULE10]
        `ADDR_CAPTURE_1: capture_1_d = wmasked[11:0]; // [RULE10]
        `ADDR_CORE_CONTROL: core_d = wmasked[15:0];
        `ADDR_SERIAL_OUT: serial_out_d = wmasked[15:0];
        `ADDR_SERIAL_IN: serial_in_d = wmasked[7:0];
        `ADDR_PIN_FUNC_0: pin_func_0_d = wmasked[23:0];
        `ADDR_PIN_FUNC_1: pin_func_1_d = wmasked[23:0];
        `ADDR_AUX_POWER: aux_power_d = wmasked[15:0];
        `ADDR_AUX_ENABLE: aux_enable_d = wmasked[15:0];
        `ADDR_OSC_SHUTDOWN: osc_d = wmasked[15:0];
        `ADDR_OUT_CONV_SETUP: conv_setup_d = wmasked[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      capture_0_q <= 12'h000;
      capture_1_q <= 12'h000;
      core_q <= 16'h0000;
      serial_out_q <= 16'h0000;
      serial_in_q <= 8'h00;
      pin_func_0_q <= 24'h00_0000;
      pin_func_1_q <= 24'h00_0000;
      aux_power_q <= 16'h0000;
      aux_enable_q <= 16'h0000;
      osc_q <= 16'h0000;
      conv_setup_q <= 16'h0000;
    end else begin
      capture_0_q <= capture_0_d;
      capture_1_q <= capture_1_d;
      core_q <= core_d;
      serial_out_q <= serial_out_d;
      serial_in_q <= serial_in_d;
      pin_func_0_q <= pin_func_0_d;
      pin_func_1_q <= pin_func_1_d;
      aux_power_q <= aux_power_d;
      aux_enable_q <= aux_enable_d;
      osc_q <= osc_d;
      conv_setup_q <= conv_setup_d;
    end
  end

  // read data answers one cycle after the strobe; reserved and unmapped words read zero
  always_comb begin
    rdata_d = `RESET_WORD;
    rvalid_d = rd_en_i;
    if (rd_en_i) begin
      if (is_iface(addr_i)) begin
        rdata_d = {4'h0, iface_q[iface_idx]}; // [RULE2]
      end else if (is_aux(addr_i)) begin
        rdata_d = {20'h0_0000, aux_q[aux_idx]};
      end else begin
        unique case (addr_i)
          `ADDR_PIN_LEVEL: rdata_d = {20'h0_0000, pin_level_q}; // [RULE9]
          `ADDR_CAPTURE_0: rdata_d = {20'h0_0000, capture_0_q};
          `ADDR_CAPTURE_1: rdata_d = {20'h0_0000, capture_1_q};
          `ADDR_CORE_CONTROL: rdata_d = {16'h0000, core_q};
          `ADDR_SERIAL_OUT: rdata_d = {16'h0000, serial_out_q};
          `ADDR_SERIAL_IN: rdata_d = {24'h00_0000, serial_in_q};
          `ADDR_PIN_FUNC_0: rdata_d = {8'h00, pin_func_0_q};
          `ADDR_PIN_FUNC_1: rdata_d = {8'h00, pin_func_1_q};
          `ADDR_AUX_POWER: rdata_d = {16'h0000, aux_power_q};
          `ADDR_AUX_ENABLE: rdata_d = {16'h0000, aux_enable_q};
          `ADDR_OSC_SHUTDOWN: rdata_d = {16'h0000, osc_q};
          `ADDR_OUT_CONV_SETUP: rdata_d = {16'h0000, conv_setup_q};
          default: rdata_d = `RESET_WORD; // [RULE12]
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= `RESET_WORD;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign save_strobe_o = save_strobe_q;
  assign save_data_o = save_data_q;
  assign gpio_level_o = gpio_out_q;
  assign aux_data_o = aux_q;
  assign core_control_o = core_q;
  assign capture_select_0_o = capture_0_q;
  assign capture_select_1_o = capture_1_q;
  assign serial_output_config_o = serial_out_q;
  assign serial_input_config_o = serial_in_q;
  assign pin_function_config_0_o = pin_func_0_q;
  assign pin_function_config_1_o = pin_func_1_q;
  assign aux_converter_power_control_o = aux_power_q;
  assign aux_converter_enable_o = aux_enable_q;
  assign oscillator_shutdown_o = osc_q;
  assign output_converter_setup_o = conv_setup_q;

endmodule : control_register_bank

// ===== bench/control_register_bank_properties.sv
// assertions on the control register bank ports
`timescale 1ns/10ps
module control_register_bank_properties (
  input logic clk_i,
  input logic nrst_i,
  input logic [15:0] addr_i,
  input logic wr_en_i,
  input logic rd_en_i,
  input logic [31:0] wdata_i,
  input logic [31:0] rdata_o,
  input logic rvalid_o,
  input logic frame_clk_i,
  input logic save_trig_i,
  input logic save_strobe_o,
  input logic [11:0] gpio_level_o,
  input logic [15:0] core_control_o,
  input logic [15:0] oscillator_shutdown_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // cycles since a pin edge; saturates so long idle stretches never wrap
  logic fr_q, sv_q;
  logic [3:0] fr_age_q, sv_age_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fr_q <= 1'b0;
      sv_q <= 1'b0;
      fr_age_q <= 4'hf;
      sv_age_q <= 4'hf;
    end else begin
      fr_q <= frame_clk_i;
      sv_q <= save_trig_i;
      fr_age_q <= (frame_clk_i && !fr_q) ? 4'h0 : fr_age_q + 4'(fr_age_q != 4'hf);
      sv_age_q <= (save_trig_i != sv_q) ? 4'h0 : sv_age_q + 4'(sv_age_q != 4'hf);
    end
  end
  property p_rvalid; rd_en_i |=> rvalid_o; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_idle; !rd_en_i |=> !rvalid_o && rdata_o == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("read data without a read");
  property p_iface_top; rd_en_i && addr_i inside {[16'h0800:16'h0807]} |=> rdata_o[31:28] == 4'h0; endproperty
  a_iface_top: assert property (p_iface_top) else $error("parameter word top bits set");
  property p_pin_top; rd_en_i && addr_i == 16'h0808 |=> rdata_o[31:12] == 20'h0_0000; endproperty
  a_pin_top: assert property (p_pin_top) else $error("pin level upper bits set");
  property p_cap_top; rd_en_i && addr_i == 16'h081a |=> rdata_o[31:12] == 20'h0_0000; endproperty
  a_cap_top: assert property (p_cap_top) else $error("capture selector upper bits set");
  property p_rsvd; rd_en_i && addr_i inside {16'h081d, 16'h0823, 16'h0825} |=> rdata_o == 32'h0000_0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved word not zero");
  property p_core_wr; wr_en_i && addr_i == 16'h081c |=> core_control_o == 16'($past(wdata_i) & 32'h0000_31ff); endproperty
  a_core_wr: assert property (p_core_wr) else $error("core control write wrong");
  property p_osc; (oscillator_shutdown_o & 16'hfffb) == 16'h0000; endproperty
  a_osc: assert property (p_osc) else $error("oscillator reserved bit set");
  property p_save; save_strobe_o |-> (sv_age_q >= 4'h2 && sv_age_q <= 4'h8) ##1 !save_strobe_o; endproperty
  a_save: assert property (p_save) else $error("save strobe untimely");
  property p_pin_frame; $changed(gpio_level_o) |-> fr_age_q >= 4'h2 && fr_age_q <= 4'h8; endproperty
  a_pin_frame: assert property (p_pin_frame) else $error("pin levels moved off frame");
  c_save: cover property (save_strobe_o);
  c_pin: cover property ($changed(gpio_level_o));
  c_core: cover property (wr_en_i && addr_i == 16'h081c);
endmodule : control_register_bank_properties

bind control_register_bank control_register_bank_properties i_control_register_bank_properties (
  .clk_i, .nrst_i, .addr_i, .wr_en_i, .rd_en_i, .wdata_i, .rdata_o, .rvalid_o, .frame_clk_i,
  .save_trig_i, .save_strobe_o, .gpio_level_o, .core_control_o, .oscillator_shutdown_o);

// ===== bench/host_model.sv
// host side of the register strobe port
`timescale 1ns/10ps
module host_model (
  input logic clk_i,
  input logic [31:0] rdata_i,
  input logic rvalid_i,
  output logic [15:0] addr_o,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [31:0] wdata_o
);
  initial begin
    addr_o = 16'h0000;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    wdata_o = 32'h0000_0000;
  end
  // one strobe per access; data inverted after release so stale values never match
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_en_o = 1'b0;
    d = rvalid_i ? rdata_i : 32'hxxxx_xxxx;
  endtask : rd
endmodule : host_model

// ===== bench/control_register_bank_test.sv
// self-checking bench for the control register bank
`timescale 1ns/10ps
module control_register_bank_test
  import ctrl_reg_pkg::*;
;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic frame_clk_i = 1'b0;
  logic save_trig_i = 1'b0;
  logic save_edge_rising_i = 1'b1;
  logic restore_valid_i = 1'b0;
  logic [11:0] gpio_level_i = 12'h5a5;
  iface_words_t param_word_i, restore_data_i, save_data_o;
  aux_words_t aux_adc_data_i;
  logic [15:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic wr_en_i, rd_en_i, rvalid_o, save_strobe_o;
  logic [11:0] gpio_level_o;
  logic [15:0] core_control_o, oscillator_shutdown_o;
  aux_words_t aux_data_o;
  logic [11:0] capture_select_0_o, capture_select_1_o;
  logic [15:0] serial_output_config_o, aux_converter_power_control_o;
  logic [15:0] aux_converter_enable_o, output_converter_setup_o;
  logic [7:0] serial_input_config_o;
  logic [23:0] pin_function_config_0_o, pin_function_config_1_o;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  localparam logic [15:0] reg_addr [15] = '{16'h081a, 16'h081b, 16'h081c, 16'h081d, 16'h081e, 16'h081f,
    16'h0820, 16'h0821, 16'h0822, 16'h0823, 16'h0824, 16'h0825, 16'h0826, 16'h0827, 16'h0810};
  localparam logic [31:0] reg_mask [15] = '{32'h0000_0fff, 32'h0000_0fff, 32'h0000_31ff, 32'h0000_0000,
    32'h0000_3fff, 32'h0000_001f, 32'h00ff_ffff, 32'h00ff_ffff, 32'h0000_03ef, 32'h0000_0000,
    32'h0000_8000, 32'h0000_0000, 32'h0000_0004, 32'h0000_0003, 32'h0000_0000};
  control_register_bank i_control_register_bank (.clk_i, .nrst_i, .addr_i, .wr_en_i, .rd_en_i, .wdata_i,
    .rdata_o, .rvalid_o, .frame_clk_i, .save_trig_i, .save_edge_rising_i, .param_word_i, .restore_valid_i,
    .restore_data_i, .save_strobe_o, .save_data_o, .gpio_level_i, .gpio_level_o, .aux_adc_data_i,
    .aux_data_o, .core_control_o, .capture_select_0_o, .capture_select_1_o, .serial_output_config_o,
    .serial_input_config_o, .pin_function_config_0_o, .pin_function_config_1_o,
    .aux_converter_power_control_o, .aux_converter_enable_o, .oscillator_shutdown_o,
    .output_converter_setup_o);
  host_model i_host_model (.clk_i, .rdata_i(rdata_o), .rvalid_i(rvalid_o), .addr_o(addr_i),
    .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .wdata_o(wdata_i));
  always #50 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic rc(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_host_model.rd(a, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask : rc
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done
  // pin held six cycles, three times the synchroniser's minimum
  task automatic frame();
    @(posedge clk_i);
    #1 frame_clk_i = 1'b1;
    repeat (6) @(posedge clk_i);
    #1 frame_clk_i = 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : frame
  task automatic save(input logic pol, input logic lvl, input int k, input logic [27:0] exp);
    @(posedge clk_i);
    #1 save_edge_rising_i = pol;
    repeat (2) @(posedge clk_i);
    #1 save_trig_i = lvl;
    for (int n = 0; n < 20 && save_strobe_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    chk("save strobe", {31'h0, save_strobe_o}, 32'h0000_0001);
    chk("save word", {4'h0, save_data_o[k]}, {4'h0, exp});
  endtask : save
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    for (int k = 0; k < 8; k++) begin
      param_word_i[k] = 28'hfed_cba0 + 28'(k);
      restore_data_i[k] = 28'h123_4560 + 28'(k);
    end
    for (int k = 0; k < 4; k++) aux_adc_data_i[k] = 12'h3c0 + 12'(k);
    repeat (4) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    for (int a = 16'h0800; a < 16'h0828; a++) rc(16'(a), 32'h0000_0000);
    done("reset values");
    frame();
    for (int k = 0; k < 8; k++) rc(16'h0800 + 16'(k), {4'h0, param_word_i[k]});
    rc(16'h0808, 32'h0000_05a5);
    chk("aux out 3", {20'h0, aux_data_o[3]}, 32'h0000_03c3);
    i_host_model.wr(16'h0800, 32'hffff_ffff);
    i_host_model.wr(16'h0808, 32'hffff_ffff);
    i_host_model.wr(16'h0809, 32'hffff_ffff);
    rc(16'h0800, {4'h0, param_word_i[0]});
    rc(16'h0808, 32'h0000_05a5);
    rc(16'h0809, 32'h0000_03c0);
    done("refresh and refusals");
    // mode bits go first, the host may only write once they are set
    i_host_model.wr(16'h081c, 32'h0000_01c0);
    i_host_model.wr(16'h0801, 32'hffff_ffff);
    i_host_model.wr(16'h0808, 32'hffff_ffff);
    i_host_model.wr(16'h080a, 32'hffff_ffff);
    frame();
    rc(16'h0801, 32'h0fff_ffff);
    rc(16'h0808, 32'h0000_0fff);
    rc(16'h080a, 32'h0000_0fff);
    chk("aux out 1", {20'h0, aux_data_o[1]}, 32'h0000_0fff);
    chk("pin out", {20'h0, gpio_level_o}, 32'h0000_0fff);
    done("port write modes");
    save(1'b1, 1'b1, 1, 28'hfff_ffff);
    save(1'b0, 1'b0, 0, param_word_i[0]);
    done("save edges");
    @(posedge clk_i);
    #1 restore_valid_i = 1'b1;
    @(posedge clk_i);
    #1 restore_valid_i = 1'b0;
    rc(16'h0803, {4'h0, restore_data_i[3]});
    done("restore");
    for (int k = 0; k < 15; k++) begin
      i_host_model.wr(reg_addr[k], 32'hffff_ffff);
      rc(reg_addr[k], reg_mask[k]);
    end
    chk("capture out 0", {20'h0, capture_select_0_o}, 32'h0000_0fff);
    chk("capture out 1", {20'h0, capture_select_1_o}, 32'h0000_0fff);
    chk("core out", {16'h0, core_control_o}, 32'h0000_31ff);
    chk("serial out cfg", {16'h0, serial_output_config_o}, 32'h0000_3fff);
    chk("serial in cfg", {24'h0, serial_input_config_o}, 32'h0000_001f);
    chk("pin func 0", {8'h0, pin_function_config_0_o}, 32'h00ff_ffff);
    chk("pin func 1", {8'h0, pin_function_config_1_o}, 32'h00ff_ffff);
    chk("aux power", {16'h0, aux_converter_power_control_o}, 32'h0000_03ef);
    chk("aux enable", {16'h0, aux_converter_enable_o}, 32'h0000_8000);
    chk("osc shutdown", {16'h0, oscillator_shutdown_o}, 32'h0000_0004);
    chk("conv setup", {16'h0, output_converter_setup_o}, 32'h0000_0003);
    done("field masks");
    wrap_up();
  end
endmodule : control_register_bank_test
